/* common/accstk_defs.svh */
`ifndef ACCSTK_DEFS_SVH
`define ACCSTK_DEFS_SVH
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define ACCSTK_ACC_W 32
`define ACCSTK_WORD_W 16
`define ACCSTK_DEPTH 8
`define ACCSTK_ACC_RST 32'h0000_0000
`define ACCSTK_SIGN_BIT 31
`endif

/* common/accstk_pkg.sv */
`include "accstk_defs.svh"
package accstk_pkg;
	// Operation codes from the sequencer
	typedef enum logic [2:0] {
		ACCSTK_OP_NONE = 3'h0,
		ACCSTK_OP_LOAD_SINGLE = 3'h1,
		ACCSTK_OP_LOAD_DOUBLE = 3'h2,
		ACCSTK_OP_STORE = 3'h3,
		ACCSTK_OP_RESULT = 3'h4,
		ACCSTK_OP_POP = 3'h5
	} accstk_op_t;
	// One request per cycle
	typedef struct packed {
		accstk_op_t op;
		logic [`ACCSTK_ACC_W-1:0] data;
	} accstk_req_t;
	// Observable state
	typedef struct packed {
		logic [`ACCSTK_ACC_W-1:0] acc;
		logic [`ACCSTK_ACC_W-1:0] top;
		logic negative;
		logic zero;
	} accstk_stat_t;
endpackage

/* hw/accstk_top.sv */
`timescale 1ns/1ps
`include "accstk_defs.svh"
module accstk_top #(
	parameter int ACC_W = `ACCSTK_ACC_W,
	parameter int DEPTH = `ACCSTK_DEPTH
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire accstk_pkg::accstk_req_t REQ,
	input wire logic SCAN_END,
	output accstk_pkg::accstk_stat_t STAT
);
	import accstk_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [ACC_W-1:0] acc_reg;
	logic [ACC_W-1:0] acc_next;
	logic [ACC_W-1:0] stk_reg [DEPTH];
	logic [ACC_W-1:0] stk_next [DEPTH];
	logic armed_reg; // A load seen since the last store or scan end
	logic armed_next;
	logic zero_reg;
	logic zero_next;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire is_ld1 = (REQ.op == ACCSTK_OP_LOAD_SINGLE);
	wire is_ld2 = (REQ.op == ACCSTK_OP_LOAD_DOUBLE);
	wire is_load = is_ld1 | is_ld2;
	wire is_store = (REQ.op == ACCSTK_OP_STORE);
	wire is_res = (REQ.op == ACCSTK_OP_RESULT);
	wire is_pop = (REQ.op == ACCSTK_OP_POP);
	// Push only when a load follows a load with no store between
	wire do_push = is_load & armed_reg;
	// Single word keeps the upper half clear; double takes all 32 bits
	wire [ACC_W-1:0] ld_val = is_ld1 ?
		{{(ACC_W-`ACCSTK_WORD_W){1'b0}}, REQ.data[`ACCSTK_WORD_W-1:0]} :
		REQ.data;
	wire writes_acc = is_load | is_res | is_pop;

	// Accumulator next value; scan end wins so no accumulator value survives the scan
	always_comb begin
		acc_next = acc_reg;
		if (SCAN_END) begin
			acc_next = `ACCSTK_ACC_RST;
		end else if (is_load) begin
			acc_next = ld_val;
		end else if (is_res) begin
			acc_next = REQ.data;
		end else if (is_pop) begin
			acc_next = stk_reg[0];
		end
	end

	// Pending-push tracking; a new scan starts unarmed
	always_comb begin
		armed_next = armed_reg;
		if (SCAN_END || is_store) begin
			armed_next = 1'b0;
		end else if (is_load) begin
			armed_next = 1'b1;
		end
	end

	// Zero flag updates on operations that load the accumulator and clears at scan end
	always_comb begin
		zero_next = zero_reg;
		if (SCAN_END) begin
			zero_next = 1'b0;
		end else if (writes_acc) begin
			zero_next = (acc_next == '0);
		end
	end

	// ----------------------------------------
	// Stack levels, one generate entry each
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_lvl
			// Neighbour values; edge levels take the accumulator or zero,
			// chosen at elaboration so no index ever leaves the array
			wire [ACC_W-1:0] from_above;
			wire [ACC_W-1:0] from_below;
			if (g == 0) begin : g_first
				assign from_above = acc_reg;
			end else begin : g_inner_up
				assign from_above = stk_reg[g-1];
			end
			if (g == DEPTH-1) begin : g_last
				assign from_below = '0;
			end else begin : g_inner_dn
				assign from_below = stk_reg[g+1];
			end
			// Deepest old value simply falls off on a push
			always_comb begin
				stk_next[g] = stk_reg[g];
				if (!SCAN_END && do_push) begin
					stk_next[g] = from_above;
				end else if (!SCAN_END && is_pop) begin
					stk_next[g] = from_below;
				end
			end
			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					stk_reg[g] <= '0;
				end else begin
					stk_reg[g] <= stk_next[g];
				end
			end
		end
	endgenerate

	// Core registers
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			acc_reg <= `ACCSTK_ACC_RST;
			armed_reg <= 1'b0;
			zero_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			armed_reg <= armed_next;
			zero_reg <= zero_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign STAT.acc = acc_reg;
	assign STAT.top = stk_reg[0];
	assign STAT.negative = acc_reg[`ACCSTK_SIGN_BIT];
	assign STAT.zero = zero_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_ACC_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		SCAN_END |=> acc_reg == '0)
		else $error("accumulator not cleared at scan end");
	AST_LD1_HIGH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_ld1 && !SCAN_END |=> acc_reg == {16'h0000, $past(REQ.data[15:0])})
		else $error("single load wrong value");
	AST_LD2_FULL: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_ld2 && !SCAN_END |=> acc_reg == $past(REQ.data))
		else $error("double load wrong value");
	AST_RESULT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_res && !SCAN_END |=> acc_reg == $past(REQ.data))
		else $error("result not written");
	AST_PUSH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		do_push && !SCAN_END |=> stk_reg[0] == $past(acc_reg) &&
		stk_reg[DEPTH-1] == $past(stk_reg[DEPTH-2]))
		else $error("push did not shift stack");
	AST_FIRST_NOPUSH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_load && !armed_reg |=> stk_reg[0] == $past(stk_reg[0]))
		else $error("first load pushed");
	// A store must leave no push pending in the cycle after it
	AST_STORE_DISARM: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_store |=> !armed_reg)
		else $error("store left push pending");
	AST_POP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_pop && !SCAN_END |=> acc_reg == $past(stk_reg[0]) &&
		stk_reg[0] == $past(stk_reg[1]) && stk_reg[DEPTH-1] == '0)
		else $error("pop wrong");
	// Sign seen on the flag must be the sign of the written result
	AST_NEG: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_res && !SCAN_END |=> STAT.negative == $past(REQ.data[31]))
		else $error("negative flag wrong");
	AST_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		writes_acc && !SCAN_END |=> zero_reg == (acc_reg == '0))
		else $error("zero flag wrong");
	COV_PUSH: cover property (@(posedge CLK_SYS) disable iff (!RST_N) do_push);
	COV_POP: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
		do_push ##1 is_pop);
	COV_STORE: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_load ##1 is_store ##1 is_load);

	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	// Occupancy tracker, read only by the checks below; it saturates
	// because the stack itself keeps no count of lost entries
	localparam int FILL_W = $clog2(DEPTH + 1);
	logic [FILL_W-1:0] fill_reg;
	logic [FILL_W-1:0] fill_next;
	wire fill_full = (fill_reg == FILL_W'(DEPTH));
	wire fill_empty = (fill_reg == '0);

	// Count up on push, down on pop; scan end leaves the stack alone
	always_comb begin
		fill_next = fill_reg;
		if (!SCAN_END && do_push && !fill_full) begin
			fill_next = fill_reg + 1'b1;
		end else if (!SCAN_END && is_pop && !fill_empty) begin
			fill_next = fill_reg - 1'b1;
		end
	end

	// Tracker register
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			fill_reg <= '0;
		end else begin
			fill_reg <= fill_next;
		end
	end

	// ----------------------------------------
	// Further checks
	// ----------------------------------------
	// Every level moves on push and pop, not only the ends
	for (genvar h = 1; h < DEPTH; h++) begin : g_chk
		AST_LVL_PUSH: assert property (@(posedge CLK_SYS)
			disable iff (!RST_N)
			do_push && !SCAN_END |=> stk_reg[h] == $past(stk_reg[h-1]))
			else $error("push skipped a level");
		AST_LVL_POP: assert property (@(posedge CLK_SYS)
			disable iff (!RST_N)
			is_pop && !SCAN_END |=> stk_reg[h-1] == $past(stk_reg[h]))
			else $error("pop skipped a level");
	end

	// Pending push bookkeeping
	AST_LOAD_ARMS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_load && !SCAN_END |=> armed_reg)
		else $error("load did not arm push");
	AST_POP_ARM: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_pop && !SCAN_END |=> armed_reg == $past(armed_reg))
		else $error("pop changed pending push");
	AST_STORE_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_store && !SCAN_END |=> acc_reg == $past(acc_reg) &&
		stk_reg[0] == $past(stk_reg[0]))
		else $error("store moved data");
	AST_RES_NOPUSH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_res && !SCAN_END |=> stk_reg[0] == $past(stk_reg[0]) &&
		armed_reg == $past(armed_reg))
		else $error("result touched stack");

	// Scan end clears the accumulator side only
	AST_SCAN_DISARM: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		SCAN_END |=> !armed_reg && !zero_reg &&
		stk_reg[0] == $past(stk_reg[0]))
		else $error("scan end state wrong");
	AST_IDLE_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		REQ.op == ACCSTK_OP_NONE && !SCAN_END |=>
		acc_reg == $past(acc_reg) && stk_reg[0] == $past(stk_reg[0]))
		else $error("idle cycle changed state");

	// Overflow and underflow ends
	AST_FULL_DROP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		do_push && !SCAN_END && fill_full |=>
		stk_reg[DEPTH-1] == $past(stk_reg[DEPTH-2]))
		else $error("deepest level kept on overflow");
	AST_EMPTY_POP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_pop && !SCAN_END && fill_empty |=> acc_reg == '0)
		else $error("pop of empty stack not zero");

	// Flags after loads
	AST_ZERO_LOAD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_load && !SCAN_END && ld_val == '0 |=> STAT.zero)
		else $error("zero load left flag low");
	AST_NEG_LD2: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_ld2 && !SCAN_END |=>
		STAT.negative == $past(REQ.data[`ACCSTK_SIGN_BIT]))
		else $error("double load sign wrong");
	AST_LD1_POS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_ld1 && !SCAN_END |=> !STAT.negative)
		else $error("single load set sign");

	// Overflow and empty-pop scenarios are reached
	COV_FULL_PUSH: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
		do_push && fill_full);
	COV_EMPTY_POP: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
		is_pop && fill_empty);
endmodule

/* tb/accstk_seq_model.sv */
`timescale 1ns/1ps
// Sequencer stand-in: each operation lasts one cycle and is followed by an idle cycle, changed at the falling edge
module accstk_seq_model (
	input wire logic clk,
	output accstk_pkg::accstk_req_t req,
	output logic scan_end
);
	import accstk_pkg::*;
	initial begin
		req = '0;
		scan_end = 1'b0;
	end
	// Idle data is inverted so a stale operand never looks valid
	task automatic issue(input accstk_op_t op, input logic [31:0] d);
		@(negedge clk);
		req <= '{op, d};
		@(negedge clk);
		req <= '{ACCSTK_OP_NONE, ~d};
	endtask
	// One-cycle end-of-scan pulse
	task automatic pulse_end();
		@(negedge clk);
		scan_end <= 1'b1;
		@(negedge clk);
		scan_end <= 1'b0;
	endtask
endmodule

/* tb/accstk_tb_top.sv */
`timescale 1ns/1ps
module accumulator_with_push_stack_tb_top;
	import accstk_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	accstk_req_t req;
	logic scan_end;
	accstk_stat_t stat;
	int fail_count = 0;
	int samples_checked = 0;
	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;
	accstk_seq_model seq (.clk(clk_sys), .req(req), .scan_end(scan_end));
	accstk_top dut (
		.CLK_SYS(clk_sys),
		.RST_N(rst_n),
		.REQ(req),
		.SCAN_END(scan_end),
		.STAT(stat)
	);
	// ----------------------------------------
	// Checks and closing
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_push_pop();
		check(stat.acc, 32'h0);
		check(stat.top, 32'h0);
		seq.issue(ACCSTK_OP_LOAD_DOUBLE, 32'h8765_4321);
		check(stat.acc, 32'h8765_4321);
		check(stat.top, 32'h0);
		check(stat.negative, 1'b1);
		seq.issue(ACCSTK_OP_LOAD_SINGLE, 32'hffff_0000);
		check(stat.acc, 32'h0);
		check(stat.zero, 1'b1);
		check(stat.top, 32'h8765_4321);
		seq.issue(ACCSTK_OP_POP, 32'h0);
		check(stat.acc, 32'h8765_4321);
		check(stat.top, 32'h0);
		seq.issue(ACCSTK_OP_STORE, 32'h0);
		seq.issue(ACCSTK_OP_LOAD_SINGLE, 32'h0000_1234);
		check(stat.acc, 32'h1234);
		check(stat.top, 32'h0);
		$display("test push_pop done");
	endtask
	// Ten loads overfill eight levels; oldest value must be gone
	task automatic t_deep();
		seq.pulse_end();
		for (int i = 1; i <= 10; i++) begin
			seq.issue(ACCSTK_OP_LOAD_SINGLE, i);
		end
		check(stat.top, 32'h9);
		for (int i = 9; i >= 1; i--) begin
			seq.issue(ACCSTK_OP_POP, 32'h0);
			check(stat.acc, i > 1 ? i : 0);
		end
		$display("test deep done");
	endtask
	task automatic t_result();
		seq.issue(ACCSTK_OP_LOAD_SINGLE, 32'h5);
		seq.issue(ACCSTK_OP_RESULT, 32'h8000_0000);
		check(stat.acc, 32'h8000_0000);
		check(stat.negative, 1'b1);
		seq.issue(ACCSTK_OP_RESULT, 32'h0);
		check(stat.zero, 1'b1);
		seq.issue(ACCSTK_OP_RESULT, 32'h9876_5432);
		seq.pulse_end();
		check(stat.acc, 32'h0);
		check(stat.zero, 1'b0);
		$display("test result done");
	endtask
	// Main sequence: reset two cycles, then scenarios
	initial begin
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		t_push_pop();
		t_deep();
		t_result();
		wrap_up();
	end
	// Watchdog: tests need well under 200 cycles
	initial begin
		repeat (2000) @(posedge clk_sys);
		fail_count++;
		wrap_up();
	end
endmodule
